// ===== pco_consts.svh
// Offsets, field positions, reset values and source numbers of the
// pin-change port override block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PCO_CONSTS_SVH
`define PCO_CONSTS_SVH

// Register byte offsets on the APB window
`define PCO_CTRL_OFF 8'h00
`define PCO_MASK_H_OFF 8'h04
`define PCO_MASK_J_OFF 8'h08
`define PCO_LEVEL_OFF 8'h0C
`define PCO_INT_STAT_OFF 8'h10
`define PCO_INT_MASK_OFF 8'h14
`define PCO_DIE_OVR_OFF 8'h18
`define PCO_INFO_OFF 8'h1C

// Field positions
`define PCO_CTRL_GROUP_EN_BIT 0
`define PCO_INT_H_BIT 0
`define PCO_INT_J_BIT 1
`define PCO_LEVEL_J_LSB 8
`define PCO_INFO_J_PRESENT_BIT 16

// Reset values
`define PCO_CTRL_RST 1'h0
`define PCO_MASK_RST 8'h00
`define PCO_INT_MASK_RST 2'h0

// Pin-change source numbering
`define PCO_H_FIRST_SRC 8'h10
`define PCO_J_FIRST_SRC 8'h18
`define PCO_J_LAST_SRC 8'h1E

`endif

// ===== pco_pkg.sv
// Types shared by the pin-change port override block.
// Assumes a plain APB master with 32-bit data.
package pco_pkg;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pco_apb_req_type;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } pco_apb_rsp_type;

    // Override set handed to the port pad logic, one bit per pin
    typedef struct packed {
        logic [7:0] pullup_override_en;
        logic [7:0] pullup_override_val;
        logic [7:0] direction_override_en;
        logic [7:0] direction_override_val;
        logic [7:0] outvalue_override_en;
        logic [7:0] outvalue_override_val;
        logic [7:0] input_enable_override_en;
        logic [7:0] input_enable_override_val;
    } pco_ovr_type;

endpackage

// ===== pco_port_ovr.sv
// Override and routing logic for one port whose pins feed pin-change
// sources. Assumes pins synchronous to clk, width of at most 8.
`timescale 1ns/1ps
module pco_port_ovr #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins and control
    input wire logic [WIDTH-1:0] pin_digital_input,
    input wire logic [WIDTH-1:0] pin_change_source_mask,
    input wire logic pin_change_group_enable,
    // Results
    output pco_pkg::pco_ovr_type ovr_ff,
    output logic [WIDTH-1:0] src_level_ff,
    output logic change_ff
);
    import pco_pkg::*;

    pco_ovr_type nxt_ovr;
    logic [7:0] die_en;

    initial begin
        if (WIDTH < 1 || WIDTH > 8) begin
            $error("pco_port_ovr: WIDTH must be 1 to 8");
        end
    end

    // Pins above WIDTH have no source and keep every override off
    assign die_en = 8'(pin_change_source_mask & {WIDTH{pin_change_group_enable}});

    // Pull-up, direction and output overrides never act on these pins
    always_comb begin
        nxt_ovr = '0; // see [RULE4] see [RULE7]
        nxt_ovr.input_enable_override_en = die_en; // see [RULE5] see [RULE8]
        nxt_ovr.input_enable_override_val = 8'h00;
    end

    // Registered so the pad sees glitch-free overrides
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovr_ff <= '0;
        end else begin
            ovr_ff <= nxt_ovr;
        end
    end

    // Pin level forwarded to the detector, bit k is source first+k
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_level_ff <= '0;
        end else begin
            src_level_ff <= pin_digital_input; // see [RULE6] see [RULE9]
        end
    end

    // Change on an enabled, unmasked pin; first edge after reset may
    // report pins that rest high, a small price for a constant reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            change_ff <= 1'b0;
        end else begin
            change_ff <= |((pin_digital_input ^ src_level_ff)
                & die_en[WIDTH-1:0]);
        end
    end

endmodule

// ===== pco_irq_bank.sv
// Sticky interrupt status with mask and one level interrupt output.
// Assumes clear requests arrive as one-cycle write-one-to-clear masks.
`timescale 1ns/1ps
module pco_irq_bank #(
    parameter int N = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Events and software access
    input wire logic [N-1:0] event_in,
    input wire logic [N-1:0] clear,
    input wire logic [N-1:0] mask,
    // State
    output logic [N-1:0] status_ff,
    output logic irq_ff
);
    logic [N-1:0] nxt_status;

    initial begin
        if (N < 1) begin
            $error("pco_irq_bank: N must be at least 1");
        end
    end

    // Set wins over a clear in the same cycle, so no event is lost
    assign nxt_status = (status_ff & ~clear) | event_in;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= |(nxt_status & mask);
        end
    end

endmodule

// ===== pco_top.sv
// Pin-change port override block: APB registers, two port override
// units and the interrupt bank.
// Assumes an APB master on clk, pins already synchronous to clk.
//
// Behaviour
// [RULE1] First port bits 0-7 feed sources 16-23
// [RULE2] Second port bits 0-6 feed sources 24-30
// [RULE3] Second port exists only on large variants
// [RULE4] First port pull, direction, output overrides off
// [RULE5] First port input override: mask AND group
// [RULE6] First port pin level goes to detector
// [RULE7] Second port pull, direction, output overrides off
// [RULE8] Second port input override: mask AND group
// [RULE9] Second port pin level goes to detector
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pco_consts.svh"
module pco_top #(
    parameter int H_WIDTH = 8,
    parameter int J_WIDTH = 7,
    parameter bit HAS_PORT_J = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire pco_pkg::pco_apb_req_type apb_req,
    output pco_pkg::pco_apb_rsp_type apb_rsp,
    // First port pins
    input wire logic [7:0] port_h_pin_digital_input,
    output pco_pkg::pco_ovr_type port_h_ovr,
    // Second port pins
    input wire logic [6:0] port_j_pin_digital_input,
    output pco_pkg::pco_ovr_type port_j_ovr,
    // To the pin-change detector, bit k is source 16+k
    output logic [14:0] pin_change_level,
    // Interrupt
    output logic irq
);
    import pco_pkg::*;

    // Elaboration checks on the port shapes
    initial begin
        if (H_WIDTH != 8) begin
            $error("pco_top: first port must have 8 sources");
        end
        if (J_WIDTH != 7) begin
            $error("pco_top: second port must have 7 sources");
        end
    end

    // Software-visible state
    logic group_en_ff;
    logic [7:0] mask_h_ff;
    logic [6:0] mask_j_ff;
    logic [1:0] int_mask_ff;

    // APB answer registers
    logic pready_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;

    // Decoded transfer phases
    logic access;
    logic wr_take;
    logic rd_prep;
    logic addr_hit;

    // Sub-unit results
    pco_ovr_type h_ovr;
    pco_ovr_type j_ovr;
    logic [7:0] h_level;
    logic [6:0] j_level;
    logic h_change;
    logic j_change;
    logic [1:0] int_stat;
    logic irq_int;
    logic [1:0] int_clear;
    logic [1:0] int_event;

    // The access phase lasts two cycles: pready rises on the second,
    // which gives the read mux a full cycle without a long path
    assign access = apb_req.psel & apb_req.penable;
    assign rd_prep = access & ~pready_ff;
    assign wr_take = access & pready_ff & apb_req.pwrite;

    // Known offsets; the second port mask is refused when it is absent
    always_comb begin
        case (apb_req.paddr)
            `PCO_CTRL_OFF: addr_hit = 1'b1;
            `PCO_MASK_H_OFF: addr_hit = 1'b1;
            `PCO_MASK_J_OFF: addr_hit = HAS_PORT_J;
            `PCO_LEVEL_OFF: addr_hit = 1'b1;
            `PCO_INT_STAT_OFF: addr_hit = 1'b1;
            `PCO_INT_MASK_OFF: addr_hit = 1'b1;
            `PCO_DIE_OVR_OFF: addr_hit = 1'b1;
            `PCO_INFO_OFF: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // Read mux; reserved bits read as zero
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (apb_req.paddr)
            `PCO_CTRL_OFF: begin
                nxt_prdata[`PCO_CTRL_GROUP_EN_BIT] = group_en_ff;
            end
            `PCO_MASK_H_OFF: begin
                nxt_prdata[7:0] = mask_h_ff;
            end
            `PCO_MASK_J_OFF: begin
                nxt_prdata[6:0] = mask_j_ff;
            end
            `PCO_LEVEL_OFF: begin
                nxt_prdata[7:0] = h_level;
                nxt_prdata[`PCO_LEVEL_J_LSB +: 7] = j_level;
            end
            `PCO_INT_STAT_OFF: begin
                nxt_prdata[1:0] = int_stat;
            end
            `PCO_INT_MASK_OFF: begin
                nxt_prdata[1:0] = int_mask_ff;
            end
            `PCO_DIE_OVR_OFF: begin
                nxt_prdata[7:0] = h_ovr.input_enable_override_en;
                nxt_prdata[`PCO_LEVEL_J_LSB +: 7] =
                    j_ovr.input_enable_override_en[6:0];
            end
            `PCO_INFO_OFF: begin
                nxt_prdata[7:0] = `PCO_H_FIRST_SRC;
                nxt_prdata[15:8] = HAS_PORT_J ? `PCO_J_LAST_SRC : 8'h00;
                nxt_prdata[`PCO_INFO_J_PRESENT_BIT] = HAS_PORT_J;
            end
            default: begin
                nxt_prdata = 32'h0000_0000;
            end
        endcase
    end

    // Unmapped offsets answer with an error, reads returning zero
    assign nxt_pslverr = ~addr_hit;

    // APB answer timing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= access & ~pready_ff;
        end
    end

    // Read data and error are captured in the first access cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (rd_prep) begin
            prdata_ff <= apb_req.pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end else if (!access) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
    end

    assign apb_rsp.pready = pready_ff;
    assign apb_rsp.prdata = prdata_ff;
    assign apb_rsp.pslverr = pslverr_ff;

    // Group enable shared by both ports
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            group_en_ff <= `PCO_CTRL_RST;
        end else if (wr_take && apb_req.paddr == `PCO_CTRL_OFF) begin
            group_en_ff <= apb_req.pwdata[`PCO_CTRL_GROUP_EN_BIT];
        end
    end

    // Source mask of the first port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_h_ff <= `PCO_MASK_RST;
        end else if (wr_take && apb_req.paddr == `PCO_MASK_H_OFF) begin
            mask_h_ff <= apb_req.pwdata[7:0];
        end
    end

    // Source mask of the second port; held at zero when it is absent
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_j_ff <= 7'(`PCO_MASK_RST);
        end else if (HAS_PORT_J && wr_take
            && apb_req.paddr == `PCO_MASK_J_OFF) begin
            mask_j_ff <= apb_req.pwdata[6:0]; // see [RULE3]
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_mask_ff <= `PCO_INT_MASK_RST;
        end else if (wr_take && apb_req.paddr == `PCO_INT_MASK_OFF) begin
            int_mask_ff <= apb_req.pwdata[1:0];
        end
    end

    // Write-one-to-clear pulse for the status bits
    assign int_clear = (wr_take && apb_req.paddr == `PCO_INT_STAT_OFF)
        ? apb_req.pwdata[1:0] : 2'h0;

    // First port: sources 16 to 23 in bit order
    pco_port_ovr #(
        .WIDTH(H_WIDTH)
    ) u_port_h (
        .clk(clk),
        .resetn(resetn),
        .pin_digital_input(port_h_pin_digital_input),
        .pin_change_source_mask(mask_h_ff),
        .pin_change_group_enable(group_en_ff),
        .ovr_ff(h_ovr),
        .src_level_ff(h_level), // see [RULE1]
        .change_ff(h_change)
    );

    // Second port only on the large variants; otherwise all quiet
    generate
        if (HAS_PORT_J) begin : g_port_j
            pco_port_ovr #(
                .WIDTH(J_WIDTH)
            ) u_port_j (
                .clk(clk),
                .resetn(resetn),
                .pin_digital_input(port_j_pin_digital_input),
                .pin_change_source_mask(mask_j_ff),
                .pin_change_group_enable(group_en_ff),
                .ovr_ff(j_ovr),
                .src_level_ff(j_level), // see [RULE2]
                .change_ff(j_change)
            );
        end else begin : g_no_port_j
            assign j_ovr = '0; // see [RULE3]
            assign j_level = 7'h00;
            assign j_change = 1'b0;
        end
    endgenerate

    // Each port raises its own sticky status bit
    assign int_event[`PCO_INT_H_BIT] = h_change;
    assign int_event[`PCO_INT_J_BIT] = j_change;

    pco_irq_bank #(
        .N(2)
    ) u_irq (
        .clk(clk),
        .resetn(resetn),
        .event_in(int_event),
        .clear(int_clear),
        .mask(int_mask_ff),
        .status_ff(int_stat),
        .irq_ff(irq_int)
    );

    // Outputs come straight from the sub-unit flip-flops; an absent second port gives zero
    assign port_h_ovr = h_ovr;
    assign port_j_ovr = j_ovr;
    // Source 16+k sits at bit k: first port low, second port high
    assign pin_change_level = {j_level, h_level}; // see [RULE1] see [RULE2]
    assign irq = irq_int;

endmodule

// ===== pco_top_sva.sv
// Checker for the pin-change port override top, on its ports only.
// Assumes one clock domain and the offsets of the constants header.
`timescale 1ns/1ps
`include "pco_consts.svh"
module pco_top_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bus and pins
    input wire pco_pkg::pco_apb_req_type apb_req,
    input wire pco_pkg::pco_apb_rsp_type apb_rsp,
    input wire logic [7:0] port_h_pin_digital_input,
    input wire logic [6:0] port_j_pin_digital_input,
    // Results
    input wire pco_pkg::pco_ovr_type port_h_ovr,
    input wire pco_pkg::pco_ovr_type port_j_ovr,
    input wire logic [14:0] pin_change_level,
    input wire logic irq
);
    import pco_pkg::*;
    logic wr_done;
    logic grp_ff;
    logic [7:0] mh_ff;
    logic [6:0] mj_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    assign wr_done = apb_req.psel & apb_req.penable & apb_rsp.pready
        & apb_req.pwrite;
    // Mirror of the controls, taken where the bus write completes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            grp_ff <= 1'b0;
            mh_ff <= 8'h00;
            mj_ff <= 7'h00;
        end else if (wr_done) begin
            if (apb_req.paddr == `PCO_CTRL_OFF) grp_ff <= apb_req.pwdata[0];
            if (apb_req.paddr == `PCO_MASK_H_OFF) mh_ff <= apb_req.pwdata[7:0];
            if (apb_req.paddr == `PCO_MASK_J_OFF) mj_ff <= apb_req.pwdata[6:0];
        end
    end
    a_h_fixed_off: assert property (port_h_ovr[63:16] == 48'h0)
        else $error("port H fixed overrides not zero");
    a_h_die_val: assert property (port_h_ovr[7:0] == 8'h00)
        else $error("port H input override value not zero");
    a_h_die_en: assert property (
        port_h_ovr.input_enable_override_en ==
        ({8{$past(grp_ff)}} & $past(mh_ff)))
        else $error("port H input override enable wrong");
    a_j_fixed_off: assert property (port_j_ovr[63:16] == 48'h0)
        else $error("port J fixed overrides not zero");
    a_j_die_val: assert property (port_j_ovr[7:0] == 8'h00)
        else $error("port J input override value not zero");
    a_j_die_en: assert property (
        port_j_ovr.input_enable_override_en ==
        {1'b0, {7{$past(grp_ff)}} & $past(mj_ff)})
        else $error("port J input override enable wrong");
    a_h_route: assert property ($past(resetn, 2) |->
        pin_change_level[7:0] == $past(port_h_pin_digital_input))
        else $error("port H level not routed");
    a_j_route: assert property ($past(resetn, 2) |->
        pin_change_level[14:8] == $past(port_j_pin_digital_input))
        else $error("port J level not routed");
endmodule

bind pco_top pco_top_sva u_sva (.clk(clk), .resetn(resetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .port_h_pin_digital_input(port_h_pin_digital_input),
    .port_j_pin_digital_input(port_j_pin_digital_input),
    .port_h_ovr(port_h_ovr), .port_j_ovr(port_j_ovr),
    .pin_change_level(pin_change_level), .irq(irq));

// ===== pco_pin_model.sv
// Model of the outside pins of both ports.
// Assumes pin levels settle one edge after a command, as synced inputs.
`timescale 1ns/1ps
module pco_pin_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Commanded levels
    input wire logic [7:0] h_set,
    input wire logic [6:0] j_set,
    // Pins
    output logic [7:0] h_pin,
    output logic [6:0] j_pin
);
    // Pins rest low in reset so no change is seen on release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            h_pin <= 8'h00;
            j_pin <= 7'h00;
        end else begin
            h_pin <= h_set;
            j_pin <= j_set;
        end
    end
endmodule

// ===== pin_change_port_override_bench.sv
// Self-checking bench for the pin-change port override block.
// Assumes the top module, pin model and checker are compiled first.
`timescale 1ns/1ps
`include "pco_consts.svh"
module pin_change_port_override_bench;
    import pco_pkg::*;
    logic clk;
    logic resetn;
    pco_apb_req_type apb_req;
    pco_apb_rsp_type apb_rsp;
    logic [7:0] h_set;
    logic [6:0] j_set;
    logic [7:0] h_pin;
    logic [6:0] j_pin;
    logic [14:0] level;
    logic irq;
    logic [32:0] exp_q[$];
    logic [7:0] mh;
    logic [6:0] mj;
    int err_count;
    int total_checks;
    pco_top dut (.clk(clk), .resetn(resetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .port_h_pin_digital_input(h_pin),
        .port_h_ovr(), .port_j_pin_digital_input(j_pin), .port_j_ovr(),
        .pin_change_level(level), .irq(irq));
    pco_pin_model pins (.clk(clk), .resetn(resetn), .h_set(h_set),
        .j_set(j_set), .h_pin(h_pin), .j_pin(j_pin));
    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [32:0] seen,
        input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One transfer; the idle edge at the end keeps strobes single-driven
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        @(posedge clk);
        while (apb_rsp.pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            give_verdict();
        end
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Read answers are compared in bus order with the noted values
    always @(posedge clk) begin
        if ((apb_req.psel & apb_req.penable & apb_rsp.pready
            & ~apb_req.pwrite) === 1'b1) begin
            chk("read", {apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'h40261F4A));
        resetn = 1'b0;
        apb_req = '0;
        h_set = 8'h00;
        j_set = 7'h00;
        err_count = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(`PCO_CTRL_OFF, 33'h0);
        rd(`PCO_MASK_J_OFF, 33'h0);
        rd(`PCO_INFO_OFF, 33'h11E10);
        rd(8'h20, 33'h100000000);
        // Overrides follow mask AND group, group off and on
        for (int i = 0; i < 6; i++) begin
            mh = 8'($urandom);
            mj = 7'($urandom);
            wr(`PCO_CTRL_OFF, {31'h0, i[0]});
            wr(`PCO_MASK_H_OFF, {24'h0, mh});
            wr(`PCO_MASK_J_OFF, {25'h0, mj});
            rd(`PCO_MASK_H_OFF, {25'h0, mh});
            rd(`PCO_DIE_OVR_OFF, {18'h0, mj & {7{i[0]}}, mh & {8{i[0]}}});
        end
        // Random pin levels reach the detector, bit k is source 16+k
        for (int i = 0; i < 6; i++) begin
            h_set <= 8'($urandom);
            j_set <= 7'($urandom);
            repeat (3) @(posedge clk);
            rd(`PCO_LEVEL_OFF, {18'h0, j_set, h_set});
        end
        // Only pins with the override enabled raise the status bits
        wr(`PCO_INT_STAT_OFF, 32'h3);
        wr(`PCO_CTRL_OFF, 32'h1);
        wr(`PCO_MASK_H_OFF, 32'h01);
        wr(`PCO_MASK_J_OFF, 32'h40);
        wr(`PCO_INT_MASK_OFF, 32'h1);
        h_set <= h_set ^ 8'h80;
        j_set <= j_set ^ 7'h40;
        repeat (4) @(posedge clk);
        rd(`PCO_INT_STAT_OFF, 33'h2);
        chk("irq", {32'h0, irq}, 33'h0);
        h_set <= h_set ^ 8'h01;
        repeat (4) @(posedge clk);
        chk("irq", {32'h0, irq}, 33'h1);
        rd(`PCO_INT_STAT_OFF, 33'h3);
        wr(`PCO_INT_STAT_OFF, 32'h1);
        rd(`PCO_INT_STAT_OFF, 33'h2);
        chk("irq", {32'h0, irq}, 33'h0);
        wr(`PCO_INT_MASK_OFF, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", {32'h0, irq}, 33'h1);
        // Group off: a change on source 30 is not seen
        wr(`PCO_INT_STAT_OFF, 32'h3);
        wr(`PCO_CTRL_OFF, 32'h0);
        j_set <= j_set ^ 7'h40;
        repeat (4) @(posedge clk);
        rd(`PCO_INT_STAT_OFF, 33'h0);
        give_verdict();
    end
endmodule
